// ==== src/tsm_params.svh ====
// Constants for the testable safety input monitor
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// ========================================
// Timing
`define TSM_CLK_HZ 100000000
`define TSM_MS_CYCLES (`TSM_CLK_HZ / 1000)
`define TSM_FILT_MIN_MS 8'd3
`define TSM_FILT_MAX_MS 8'd250
`define TSM_SIMUL_MAX_MS 16'hffff

// ========================================
// Contact arrangement codes
`define TSM_MODE_SINGLE_NC 2'h0
`define TSM_MODE_DUAL_NC 2'h1
`define TSM_MODE_NC_NO 2'h2

// ========================================
// Reset type codes
`define TSM_RST_MANUAL 1'b0
`define TSM_RST_MONITORED 1'b1

`endif

// ==== src/tsm_pkg.sv ====
// Types for the testable safety input monitor
package tsm_pkg;

    typedef enum logic [1:0] {
        TSM_MODE_SINGLE_NC = 2'h0,
        TSM_MODE_DUAL_NC = 2'h1,
        TSM_MODE_NC_NO = 2'h2,
        TSM_MODE_SPARE = 2'h3
    } tsm_mode_t;

    // Output enable sequencer, Gray coded along the usual path
    typedef enum logic [1:0] {
        TSM_ST_POWER_TEST = 2'b00,
        TSM_ST_WAIT_ACT = 2'b01,
        TSM_ST_ARMED = 2'b11,
        TSM_ST_WAIT_RESET = 2'b10
    } tsm_state_t;

endpackage

// ==== src/tsm_tick.sv ====
// Millisecond tick divider
`include "tsm_params.svh"

module tsm_tick
#(
    // Clock cycles per millisecond tick
    parameter int MS_CYCLES = `TSM_MS_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // One-cycle pulse each millisecond
    output logic ms_tick
);

    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;
    wire logic wrap;

    assign wrap = (cnt_reg == 17'(MS_CYCLES - 1));
    assign cnt_next = wrap ? 17'h0 : cnt_reg + 17'h1;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= 17'h0;
            ms_tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            ms_tick <= wrap;
        end
    end

endmodule

// ==== src/tsm_debounce.sv ====
// Pin synchroniser and debounce filter for one contact
`include "tsm_params.svh"

module tsm_debounce
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Timing
    input wire logic ms_tick,
    input wire logic [7:0] filt_ms,
    // Contact
    input wire logic raw_pin,
    output logic filt_out
);

    logic [2:0] sync_reg;
    logic [7:0] hold_reg;
    logic [7:0] hold_next;
    wire logic sync_level;
    wire logic stable;
    wire logic differs;
    wire logic [7:0] limit;
    wire logic done;

    // Filter counts only when second and third stages agree
    assign stable = (sync_reg[1] == sync_reg[2]);
    assign sync_level = sync_reg[2];
    assign differs = stable && (sync_level != filt_out);
    assign limit = (filt_ms < `TSM_FILT_MIN_MS) ? `TSM_FILT_MIN_MS :
                   (filt_ms > `TSM_FILT_MAX_MS) ? `TSM_FILT_MAX_MS : filt_ms;
    assign done = ms_tick && (hold_reg + 8'h1 >= limit);
    assign hold_next = !differs ? 8'h0 :
                       ms_tick ? hold_reg + 8'h1 : hold_reg;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_reg <= 3'h0;
            hold_reg <= 8'h0;
            filt_out <= 1'b0;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], raw_pin};
            if (differs && done)
            begin
                filt_out <= sync_level;
                hold_reg <= 8'h0;
            end
            else
            begin
                hold_reg <= hold_next;
            end
        end
    end

endmodule

// ==== src/tsm_monitor.sv ====
// Testable safety input monitor: top level
// How it works
// - Single NC follows first contact; dual NC needs both contacts at 1.
// - NC plus NO mode enables only when first is 1 and second 0.
// - Disagreement longer than skew window flags fault and forces output 0.
// - With reset required, output stays 0 after activation until reset.
// - Manual reset type accepts one rising edge of the reset input.
// - Monitored reset type needs rise then fall of the reset input.
// - Power-on test needs one activation then release before first enable.
// - Each contact is debounced with a filter of 3 to 250 ms.
// - Skew check runs only when simultaneity enable is set.
// - Simultaneity time in ms bounds the switching skew of contacts.
// - Fault output asserts on any fault when fault report is enabled.
`include "tsm_params.svh"

module tsm_monitor
#(
    // Clock cycles per millisecond tick
    parameter int MS_CYCLES = `TSM_MS_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Contacts and reset pushbutton
    input wire logic first_contact_input,
    input wire logic second_contact_input,
    input wire logic reset_button,
    // Configuration
    input wire logic [1:0] contact_mode,
    input wire logic reset_required,
    input wire logic reset_monitored,
    input wire logic power_test_en,
    input wire logic [7:0] filter_ms,
    input wire logic simul_en,
    input wire logic [15:0] simul_ms,
    input wire logic fault_report_en,
    // Results
    output logic safe_out,
    output logic fault_out,
    output logic simul_fault
);

    wire logic ms_tick;
    wire logic filt_a;
    wire logic filt_b;
    wire logic filt_rst;
    wire logic single_mode;
    wire logic cond_ok;
    wire logic agree;
    wire logic skew_expired;
    wire logic rst_rise;
    wire logic rst_fall;
    wire logic reset_seen;
    wire logic out_next;

    tsm_pkg::tsm_state_t state_reg;
    tsm_pkg::tsm_state_t state_next;
    logic [15:0] skew_reg;
    logic rst_prev_reg;
    logic rst_armed_reg;
    // Sensor seen clear once since power-on
    logic pt_clear_reg;

    tsm_tick
    #(
        .MS_CYCLES(MS_CYCLES)
    )
    u_tick
    (
        .mclk(mclk),
        .resetn(resetn),
        .ms_tick(ms_tick)
    );

    tsm_debounce u_deb_a
    (
        .mclk(mclk),
        .resetn(resetn),
        .ms_tick(ms_tick),
        .filt_ms(filter_ms),
        .raw_pin(first_contact_input),
        .filt_out(filt_a)
    );

    tsm_debounce u_deb_b
    (
        .mclk(mclk),
        .resetn(resetn),
        .ms_tick(ms_tick),
        .filt_ms(filter_ms),
        .raw_pin(second_contact_input),
        .filt_out(filt_b)
    );

    tsm_debounce u_deb_rst
    (
        .mclk(mclk),
        .resetn(resetn),
        .ms_tick(ms_tick),
        .filt_ms(filter_ms),
        .raw_pin(reset_button),
        .filt_out(filt_rst)
    );

    // ========================================
    // Contact evaluation
    assign single_mode = (contact_mode == `TSM_MODE_SINGLE_NC);
    assign cond_ok = single_mode ? filt_a :
                     (contact_mode == `TSM_MODE_DUAL_NC) ? (filt_a & filt_b) :
                     (contact_mode == `TSM_MODE_NC_NO) ? (filt_a & ~filt_b) :
                     1'b0;
    assign agree = single_mode ||
                   ((contact_mode == `TSM_MODE_DUAL_NC) ? (filt_a == filt_b)
                                                        : (filt_a != filt_b));

    // ========================================
    // Simultaneity window
    // window length in ms
    assign skew_expired = ms_tick && (skew_reg >= simul_ms);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            skew_reg <= 16'h0;
        else if (agree || !simul_en)
            skew_reg <= 16'h0;
        else if (ms_tick && skew_reg != `TSM_SIMUL_MAX_MS)
            skew_reg <= skew_reg + 16'h1;
    end

    // ========================================
    // Reset pushbutton edges
    assign rst_rise = filt_rst && !rst_prev_reg;
    assign rst_fall = !filt_rst && rst_prev_reg;
    assign reset_seen = reset_monitored ? (rst_fall && rst_armed_reg)
                                        : rst_rise;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_prev_reg <= 1'b0;
            rst_armed_reg <= 1'b0;
        end
        else
        begin
            rst_prev_reg <= filt_rst;
            if (rst_rise)
                rst_armed_reg <= 1'b1;
            else if (rst_fall)
                rst_armed_reg <= 1'b0;
        end
    end

    // ========================================
    // Power-on test: filters start low, so a clear sensor must be seen
    // first, or the reset level would pass as an activation
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pt_clear_reg <= 1'b0;
        else if (state_reg == tsm_pkg::TSM_ST_POWER_TEST && cond_ok)
            pt_clear_reg <= 1'b1;
    end

    // ========================================
    // Simultaneity fault latch
    logic fault_next;
    always_comb
    begin
        fault_next = simul_fault;
        // clear needs safe pair, and reset when reset is required
        if (simul_fault && agree && cond_ok &&
            (!reset_required || reset_seen))
            fault_next = 1'b0;
        if (simul_en && !agree && skew_expired)
            fault_next = 1'b1;
    end

    // ========================================
    // Output enable sequencer
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            tsm_pkg::TSM_ST_POWER_TEST:
                if (!cond_ok && pt_clear_reg)
                    state_next = tsm_pkg::TSM_ST_WAIT_ACT;
            // Release after the test still asks for a reset when reset is required
            tsm_pkg::TSM_ST_WAIT_ACT:
                if (cond_ok)
                    state_next = reset_required
                                 ? tsm_pkg::TSM_ST_WAIT_RESET
                                 : tsm_pkg::TSM_ST_ARMED;
            tsm_pkg::TSM_ST_ARMED:
                if (!cond_ok && reset_required)
                    state_next = tsm_pkg::TSM_ST_WAIT_RESET;
            tsm_pkg::TSM_ST_WAIT_RESET:
                if (!reset_required || (cond_ok && reset_seen))
                    state_next = tsm_pkg::TSM_ST_ARMED;
        endcase
    end

    assign out_next = (state_next == tsm_pkg::TSM_ST_ARMED) && cond_ok &&
                      !fault_next && !(simul_en && skew_reg != 16'h0 &&
                      !agree);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= tsm_pkg::TSM_ST_POWER_TEST;
            safe_out <= 1'b0;
            fault_out <= 1'b0;
            simul_fault <= 1'b0;
        end
        else
        begin
            // Power-on test applies only right after module reset
            if (state_reg == tsm_pkg::TSM_ST_POWER_TEST && !power_test_en)
                state_reg <= reset_required ? tsm_pkg::TSM_ST_WAIT_RESET
                                            : tsm_pkg::TSM_ST_ARMED;
            else
                state_reg <= state_next;
            safe_out <= out_next;
            simul_fault <= fault_next;
            fault_out <= fault_report_en && fault_next;
        end
    end

    // ========================================
    // Checks
    sequence s_fault_set;
        simul_fault;
    endsequence

    AST_SAFE_LOW_ON_FAULT: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_fault_set |-> !safe_out)
        else $error("safe output high while skew fault latched");

    AST_SAFE_NEEDS_COND: assert property (
        @(posedge mclk) disable iff (!resetn)
        safe_out |-> $past(cond_ok))
        else $error("safe output high without good contact pair");

    AST_NCNO_PAIR: assert property (
        @(posedge mclk) disable iff (!resetn)
        (safe_out && $past(contact_mode) == `TSM_MODE_NC_NO)
            |-> $past(filt_a) && !$past(filt_b))
        else $error("NC plus NO output high with wrong pair");

    AST_NO_FAULT_DISABLED: assert property (
        @(posedge mclk) disable iff (!resetn)
        !$past(simul_en) && !$past(simul_fault) |-> !simul_fault)
        else $error("skew fault raised with check disabled");

    AST_FAULT_REPORT: assert property (
        @(posedge mclk) disable iff (!resetn)
        fault_out |-> simul_fault && $past(fault_report_en))
        else $error("fault output without fault or report enable");

    AST_WAIT_RESET: assert property (
        @(posedge mclk) disable iff (!resetn)
        (state_reg == tsm_pkg::TSM_ST_WAIT_RESET && reset_required &&
         !reset_seen) |=> !safe_out)
        else $error("output enabled without reset");

    AST_POWER_TEST: assert property (
        @(posedge mclk) disable iff (!resetn)
        (state_reg == tsm_pkg::TSM_ST_POWER_TEST) |=> !safe_out)
        else $error("output enabled before power-on test");

    AST_MONITORED_FALL: assert property (
        @(posedge mclk) disable iff (!resetn)
        (reset_seen && reset_monitored) |-> !filt_rst && rst_prev_reg)
        else $error("monitored reset accepted without falling edge");

    AST_MANUAL_RISE: assert property (
        @(posedge mclk) disable iff (!resetn)
        (reset_seen && !reset_monitored) |-> filt_rst && !rst_prev_reg)
        else $error("manual reset accepted without rising edge");

endmodule

// ==== bench/tsm_sensor_model.sv ====
// Behavioural sensor contacts and reset pushbutton with contact bounce
module tsm_sensor_model
(
    // Clock
    input wire logic mclk,
    // Requested levels: button, second, first
    input wire logic [2:0] want,
    // Pins
    output logic first_contact_input,
    output logic second_contact_input,
    output logic reset_button
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] want_q = 3'h0;
    logic [2:0] chg = 3'h0;
    logic [3:0] bn = 4'h0;
    logic [2:0] pins = 3'h0;
    // =====================================
    // Changed contacts chatter before they settle
    always @(posedge mclk)
    begin
        want_q <= want;
        if (want != want_q)
        begin
            chg <= want ^ want_q;
            bn <= 4'h8;
        end
        else if (bn != 4'h0)
            bn <= bn - 4'h1;
        pins <= want ^ (bn[0] ? chg : 3'h0);
    end
    assign first_contact_input = pins[0];
    assign second_contact_input = pins[1];
    assign reset_button = pins[2];
endmodule

// ==== bench/testable_safety_input_monitor_bench.sv ====
// Self-checking bench for the testable safety input monitor
`define CHK(got, exp) \
begin n_tests++; if ((got) !== (exp)) begin failures++; \
$display("unexpected at %0t: output level mismatch", $time); end end

module testable_safety_input_monitor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // Short millisecond keeps the run small
    localparam int MS = 20;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] want = 3'h0;
    logic [1:0] contact_mode = 2'h0;
    logic reset_required = 1'b0;
    logic reset_monitored = 1'b0;
    logic power_test_en = 1'b0;
    logic [7:0] filter_ms = 8'h03;
    logic simul_en = 1'b0;
    logic [15:0] simul_ms = 16'h0000;
    logic fault_report_en = 1'b0;
    logic first_contact_input, second_contact_input, reset_button;
    logic safe_out, fault_out, simul_fault;
    logic [2:0] outs;
    int failures = 0;
    int n_tests = 0;
    assign outs = {simul_fault, fault_out, safe_out};

    tsm_sensor_model i_tsm_sensor_model (.mclk(mclk), .want(want),
        .first_contact_input(first_contact_input),
        .second_contact_input(second_contact_input),
        .reset_button(reset_button));
    tsm_monitor #(.MS_CYCLES(MS)) i_tsm_monitor (.mclk(mclk), .resetn(resetn),
        .first_contact_input(first_contact_input),
        .second_contact_input(second_contact_input),
        .reset_button(reset_button), .contact_mode(contact_mode),
        .reset_required(reset_required), .reset_monitored(reset_monitored),
        .power_test_en(power_test_en), .filter_ms(filter_ms),
        .simul_en(simul_en), .simul_ms(simul_ms),
        .fault_report_en(fault_report_en), .safe_out(safe_out),
        .fault_out(fault_out), .simul_fault(simul_fault));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // =====================================
    // Shared tasks
    task stop_test;
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wait_ms(input int n);
        repeat (n * MS) @(posedge mclk);
    endtask
    task set_pins(input logic [2:0] v);
        @(posedge mclk);
        want <= v;
    endtask
    task start(input logic [1:0] m, input logic rr, input logic rm,
        input logic pt, input logic se, input logic [15:0] sm,
        input logic fr, input logic [7:0] fm, input logic [2:0] p);
        @(posedge mclk);
        resetn <= 1'b0;
        contact_mode <= m;
        reset_required <= rr;
        reset_monitored <= rm;
        power_test_en <= pt;
        simul_en <= se;
        simul_ms <= sm;
        fault_report_en <= fr;
        filter_ms <= fm;
        want <= p;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
    endtask
    // Output must keep away from v for hold_ms, then reach v within max_ms
    task expect_out(input int idx, input logic v, input int hold_ms,
        input int max_ms);
        int i;
        logic early;
        early = 1'b0;
        for (i = 0; i < hold_ms * MS; i++)
        begin
            @(posedge mclk);
            if (outs[idx] === v)
                early = 1'b1;
        end
        `CHK(early, 1'b0)
        for (i = 0; i < max_ms * MS && outs[idx] !== v; i++)
            @(posedge mclk);
        `CHK(outs[idx], v)
        if (outs[idx] !== v)
            stop_test();
    endtask

    // =====================================
    // Scenarios
    task single_nc;
        start(tsm_pkg::TSM_MODE_SINGLE_NC, 0, 0, 0, 0, 16'h0, 0, 8'h03, 0);
        set_pins(3'h1);
        expect_out(0, 1'b1, 2, 3);
        set_pins(3'h0);
        expect_out(0, 1'b0, 2, 3);
    endtask
    task dual_nc_skew;
        start(tsm_pkg::TSM_MODE_DUAL_NC, 0, 0, 0, 1, 16'h4, 1, 8'h06, 0);
        set_pins(3'h3);
        expect_out(0, 1'b1, 5, 3);
        set_pins(3'h1);
        expect_out(0, 1'b0, 5, 3);
        expect_out(2, 1'b1, 3, 3);
        expect_out(1, 1'b1, 0, 1);
        set_pins(3'h3);
        expect_out(2, 1'b0, 0, 8);
        expect_out(0, 1'b1, 0, 2);
        expect_out(1, 1'b0, 0, 1);
    endtask
    task skew_off;
        start(tsm_pkg::TSM_MODE_DUAL_NC, 0, 0, 0, 0, 16'h4, 1, 8'h03, 3);
        expect_out(0, 1'b1, 0, 5);
        set_pins(3'h1);
        expect_out(0, 1'b0, 0, 5);
        wait_ms(10);
        `CHK(simul_fault, 1'b0)
        `CHK(fault_out, 1'b0)
    endtask
    task nc_no_manual;
        start(tsm_pkg::TSM_MODE_NC_NO, 1, 0, 0, 0, 16'h0, 0, 8'h03, 1);
        wait_ms(8);
        `CHK(safe_out, 1'b0)
        set_pins(3'h5);
        expect_out(0, 1'b1, 0, 5);
        set_pins(3'h1);
        wait_ms(5);
        `CHK(safe_out, 1'b1)
        set_pins(3'h3);
        expect_out(0, 1'b0, 2, 3);
        set_pins(3'h1);
        wait_ms(8);
        `CHK(safe_out, 1'b0)
        set_pins(3'h5);
        expect_out(0, 1'b1, 0, 5);
    endtask
    task monitored_power;
        start(tsm_pkg::TSM_MODE_DUAL_NC, 1, 1, 1, 0, 16'h0, 0, 8'h03, 3);
        wait_ms(8);
        `CHK(safe_out, 1'b0)
        set_pins(3'h2);
        wait_ms(5);
        set_pins(3'h3);
        wait_ms(5);
        set_pins(3'h7);
        wait_ms(8);
        `CHK(safe_out, 1'b0)
        set_pins(3'h3);
        expect_out(0, 1'b1, 0, 5);
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        single_nc();
        dual_nc_skew();
        skew_off();
        nc_no_manual();
        monitored_power();
        stop_test();
    end
endmodule
